// [verilog/dpl_top.sv]
// Overview of operation
// - A zero duty value keeps that channel's pin low the whole period.
// - Duty 0x80 gives half-period high time; high time scales linearly.
// - Duty 0xFF is high 255 of 256 steps, never continuously high.
// - Duty writes are buffered and applied only at the period boundary.
// - Slow select set gives a 4096 timer clock period for the channel.
// - Slow select clear gives a 256 timer clock period; one bit each.
// - A step lasts 4 bus clocks fast and 64 bus clocks slow.
// - Slow or fast, each period keeps 256 equal duty steps.
// - Steps come from the shared timer; clearing it disturbs outputs.
// - Reset clears both duty registers to zero.
// - Wait state leaves both waveforms running unchanged.
// - Entering stop freezes each pin at its present level.
// - Leaving stop by interrupt resumes normal waveform generation.
// - Global slow bit divides the bus clock by 16 more, timer included.
// - Global slow bit clears at reset and when stop is entered.
// - Slow select A, slow select B, global slow sit in bits 3, 2, 1.
`timescale 1ns/1ps
`default_nettype none
`include "dpl_params.svh"

module dpl_top
  import dpl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        stop_mode,
  input  wire logic        timer_clear,
  output logic             duty_channel_a,
  output logic             duty_channel_b
);

  dpl_top_st_t s;
  dpl_top_st_t next_s;

  logic        access;
  logic        respond;
  logic        aligned;
  logic [5:0]  idx;
  logic        hit_a;
  logic        hit_b;
  logic        hit_misc;
  logic        hit_stat;
  logic        hit_tim;
  logic        mapped;
  logic        wr_a;
  logic        wr_b;
  logic        wr_misc;
  logic [31:0] rdata;
  logic [7:0]  duty_a;
  logic [7:0]  duty_b;
  logic        tick;
  logic [15:0] tcount;

  // Address decode. Every register takes one aligned word.
  always_comb begin
    idx      = paddr[7:2];
    aligned  = (paddr[1:0] == 2'h0);
    hit_a    = aligned && (idx == `DPL_IDX_DUTY_A);
    hit_b    = aligned && (idx == `DPL_IDX_DUTY_B);
    hit_misc = aligned && (idx == `DPL_IDX_MISC);
    hit_stat = aligned && (idx == `DPL_IDX_STATUS);
    hit_tim  = aligned && (idx == `DPL_IDX_TIMER);
    mapped   = hit_a || hit_b || hit_misc || hit_stat || hit_tim;
  end

  // The access phase lasts exactly two cycles: pready rises in the
  // second, and a write lands only at the edge that samples it high.
  always_comb begin
    access  = psel && penable;
    respond = access && s.pready;
    wr_a    = respond && pwrite && hit_a;
    wr_b    = respond && pwrite && hit_b;
    wr_misc = respond && pwrite && hit_misc;
  end

  // Read data mux. Unused bits read as zero.
  always_comb begin
    rdata = 32'h0000_0000;
    if (hit_a) begin
      rdata[7:0] = duty_a;
    end else if (hit_b) begin
      rdata[7:0] = duty_b;
    end else if (hit_misc) begin
      rdata[`DPL_MISC_SFA] = s.slow_a;
      rdata[`DPL_MISC_SFB] = s.slow_b;
      rdata[`DPL_MISC_SM]  = s.slow_bus;
    end else if (hit_stat) begin
      rdata[`DPL_STAT_PIN_A] = duty_channel_a;
      rdata[`DPL_STAT_PIN_B] = duty_channel_b;
      rdata[`DPL_STAT_STOP]  = s.stop_seen;
    end else if (hit_tim) begin
      rdata[15:0] = tcount;
    end
  end

  always_comb begin
    next_s = s;
    next_s.pready = 1'b0;
    // The error flag is a pulse beside pready, never left standing.
    next_s.pslverr = 1'b0;
    // First access cycle: latch the answer and raise pready.
    if (access && !s.pready) begin
      next_s.pready  = 1'b1;
      next_s.pslverr = !mapped;
      next_s.prdata  = rdata;
    end
    // Select bits act at once; only the duty values are buffered, so
    // software must set these first or see one distorted period.
    if (wr_misc) begin
      next_s.slow_a   = pwdata[`DPL_MISC_SFA];
      next_s.slow_b   = pwdata[`DPL_MISC_SFB];
      next_s.slow_bus = pwdata[`DPL_MISC_SM];
    end
    // Entry into stop overrides a write in the same cycle, because the
    // core can not issue one while it is stopping anyway.
    if (stop_mode && !s.stop_seen) begin
      next_s.slow_bus = 1'b0;
    end
    next_s.stop_seen = stop_mode;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s.pready    <= 1'b0;
      s.pslverr   <= 1'b0;
      s.prdata    <= 32'h0000_0000;
      s.slow_a    <= `DPL_MISC_RST;
      s.slow_b    <= `DPL_MISC_RST;
      s.slow_bus  <= `DPL_MISC_RST;
      s.stop_seen <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign prdata  = s.prdata;
  assign pready  = s.pready;
  assign pslverr = s.pslverr;

  // Wait mode has no input here: nothing in the chain looks at it, so
  // both waveforms keep running. Stop halts the timer chain, so no tick
  // reaches the channels and their pin flops hold their level; when the
  // core drops stop after an interrupt the chain simply continues.
  dpl_timebase u_timebase (
    .clk         (clk),
    .rst         (rst),
    .slow_bus    (s.slow_bus),
    .halt        (stop_mode),
    .timer_clear (timer_clear),
    .tick        (tick),
    .count       (tcount)
  );

  dpl_channel u_chan_a (
    .clk     (clk),
    .rst     (rst),
    .tick    (tick),
    .slow    (s.slow_a),
    .count   (tcount[11:0]),
    .wr_en   (wr_a),
    .wr_data (pwdata[7:0]),
    .duty    (duty_a),
    .pin     (duty_channel_a)
  );

  dpl_channel u_chan_b (
    .clk     (clk),
    .rst     (rst),
    .tick    (tick),
    .slow    (s.slow_b),
    .count   (tcount[11:0]),
    .wr_en   (wr_b),
    .wr_data (pwdata[7:0]),
    .duty    (duty_b),
    .pin     (duty_channel_b)
  );

endmodule

`default_nettype wire

// [verilog/dpl_params.svh]
`ifndef DPL_PARAMS_SVH
`define DPL_PARAMS_SVH

// Register indices; the APB byte address is four times the index.
`define DPL_IDX_DUTY_A     6'h0A
`define DPL_IDX_DUTY_B     6'h0B
`define DPL_IDX_MISC       6'h0C
`define DPL_IDX_STATUS     6'h0D
`define DPL_IDX_TIMER      6'h0E

// Control register field positions.
`define DPL_MISC_SFA       3
`define DPL_MISC_SFB       2
`define DPL_MISC_SM        1

// Status register field positions.
`define DPL_STAT_PIN_A     0
`define DPL_STAT_PIN_B     1
`define DPL_STAT_STOP      2

// Reset values.
`define DPL_DUTY_RST       8'h00
`define DPL_MISC_RST       1'b0

// Bus clock is the reference divided by 1 normally, by 16 in slow bus mode.
`define DPL_SLOW_BUS_LAST  4'hF
// Timer clock is four bus clocks.
`define DPL_TIMER_LAST     2'h3

// Repetition periods in timer clocks: 256 fast, 4096 slow.
`define DPL_FAST_PERIOD    256
`define DPL_SLOW_PERIOD    4096
// A slow duty step spans 4096 / 256 = 16 timer clocks.
`define DPL_SLOW_SHIFT     4

`endif

// [verilog/dpl_pkg.sv]
`default_nettype none
package dpl_pkg;

  typedef struct packed {
    logic [3:0]  bus_div;
    logic [1:0]  tim_div;
    logic [15:0] count;
    logic        tick;
  } dpl_tb_st_t;

  typedef struct packed {
    logic [7:0] duty;
    logic [7:0] active;
    logic       pin;
  } dpl_ch_st_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        slow_a;
    logic        slow_b;
    logic        slow_bus;
    logic        stop_seen;
  } dpl_top_st_t;

endpackage

`default_nettype wire

// [verilog/dpl_timebase.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dpl_params.svh"

module dpl_timebase
  import dpl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        slow_bus,
  input  wire logic        halt,
  input  wire logic        timer_clear,
  output logic             tick,
  output logic [15:0]      count
);

  dpl_tb_st_t s;
  dpl_tb_st_t next_s;
  logic       bus_en;

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    bus_en = 1'b0;
    // Stop halts the whole chain, so no step can advance while frozen.
    if (!halt) begin
      if (slow_bus) begin
        bus_en = (s.bus_div == `DPL_SLOW_BUS_LAST);
        next_s.bus_div = s.bus_div + 4'h1;
      end else begin
        bus_en = 1'b1;
        next_s.bus_div = 4'h0;
      end
      if (bus_en) begin
        next_s.tim_div = s.tim_div + 2'h1;
        if (s.tim_div == `DPL_TIMER_LAST) begin
          next_s.count = 16'(s.count + 16'h0001);
          next_s.tick = 1'b1;
        end
      end
    end
    // Clearing the shared counter restarts every period mid-way.
    if (timer_clear) begin
      next_s.count = 16'h0000;
      next_s.tim_div = 2'h0;
      next_s.tick = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;
  assign count = s.count;

endmodule

`default_nettype wire

// [verilog/dpl_channel.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dpl_params.svh"

module dpl_channel
  import dpl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        tick,
  input  wire logic        slow,
  input  wire logic [11:0] count,
  input  wire logic        wr_en,
  input  wire logic [7:0]  wr_data,
  output logic [7:0]       duty,
  output logic             pin
);

  dpl_ch_st_t s;
  dpl_ch_st_t next_s;
  logic [7:0] step;
  logic       start;

  always_comb begin
    next_s = s;
    // Slow mode stretches each of the 256 steps to 16 timer clocks.
    if (slow) begin
      step = count[11:`DPL_SLOW_SHIFT];
      start = (count == 12'h000);
    end else begin
      step = count[7:0];
      start = (count[7:0] == 8'h00);
    end
    if (wr_en) begin
      next_s.duty = wr_data;
    end
    // The buffer moves to the comparator only when a new period begins.
    if (tick) begin
      if (start) begin
        next_s.active = s.duty;
      end
      // Zero keeps the pin low; all ones leaves one low step.
      next_s.pin = (step < next_s.active);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s.duty <= `DPL_DUTY_RST;
      s.active <= `DPL_DUTY_RST;
      s.pin <= 1'b0;
    end else begin
      s <= next_s;
    end
  end

  assign duty = s.duty;
  assign pin = s.pin;

endmodule

`default_nettype wire

// [dv/dpl_filter.sv]
`timescale 1ns/1ps
`default_nettype none
// Averaging load: accumulates the clocks the pin spends high since a clear.
module dpl_filter (
  input  wire logic        clk,
  input  wire logic        clr,
  input  wire logic        pin,
  output logic [31:0]      level
);
  always_ff @(posedge clk) begin
    if (clr) begin
      level <= 32'h0;
    end else begin
      level <= level + {31'h0, pin};
    end
  end
endmodule
`default_nettype wire

// [dv/dpl_top_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module dpl_top_monitor (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic        stop_mode,
  input  wire logic        timer_clear,
  input  wire logic        duty_channel_a,
  input  wire logic        duty_channel_b
);
  logic [18:0] hi_a;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Longest high run is 255 slow steps of 1024 clocks at slow bus speed.
  always_ff @(posedge clk) begin
    if (rst || !duty_channel_a || stop_mode || timer_clear) begin
      hi_a <= 19'h0;
    end else begin
      hi_a <= hi_a + 19'h1;
    end
  end
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("late ready");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("long ready");
  property p_err;
    pready |-> pslverr == (paddr[1:0] != 2'h0 || paddr[7:2] < 6'h0A
                           || paddr[7:2] > 6'h0E);
  endproperty
  a_err: assert property (p_err) else $error("bad error flag");
  property p_misc;
    pready && !pwrite && paddr == 8'h30 |-> prdata[31:4] == 28'h0
                                            && !prdata[0];
  endproperty
  a_misc: assert property (p_misc) else $error("misc bits");
  property p_duty;
    pready && !pwrite && !pslverr && paddr[7:3] == 5'h05
      |-> prdata[31:8] == 24'h0;
  endproperty
  a_duty: assert property (p_duty) else $error("duty width");
  property p_rst;
    $fell(rst) |-> !duty_channel_a && !duty_channel_b && !pready;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state");
  property p_freeze;
    stop_mode [*3] |-> $stable(duty_channel_a) && $stable(duty_channel_b);
  endproperty
  a_freeze: assert property (p_freeze) else $error("pin moved");
  property p_sm;
    stop_mode [*3] ##0 (pready && !pwrite && paddr == 8'h30) |-> !prdata[1];
  endproperty
  a_sm: assert property (p_sm) else $error("slow bus kept");
  property p_run; hi_a <= 19'h3FC00; endproperty
  a_run: assert property (p_run) else $error("pin stuck high");
  c_err: cover property (pready && pslverr);
  c_stop: cover property (stop_mode [*3]);
  c_wr: cover property (pready && pwrite && paddr == 8'h30);
endmodule
bind dpl_top dpl_top_monitor i_mon (.clk, .rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .stop_mode, .timer_clear,
  .duty_channel_a, .duty_channel_b);
`default_nettype wire

// [dv/dpl_top_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin checks++; if ((g) !== (x)) begin error_cnt++; \
  $display("unexpected at %0t: %0h vs %0h", $time, g, x); end end
module dpl_top_bench;
  logic        clk, rst, psel, penable, pwrite, stop_mode, timer_clear;
  logic        clr, pready, pslverr, pin_a, pin_b, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, lva, lvb, r;
  int          error_cnt, checks;
  dpl_top i_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .stop_mode, .timer_clear,
    .duty_channel_a(pin_a), .duty_channel_b(pin_b));
  dpl_filter i_fa (.clk, .clr, .pin(pin_a), .level(lva));
  dpl_filter i_fb (.clk, .clr, .pin(pin_b), .level(lvb));
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) error_cnt++;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK(r, x)
  endtask
  // Windows of 16384 and 1024 clocks are whole periods, so those counts are exact whatever the phase.
  task automatic meas(input int n, input int w);
    repeat (w) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic tell(input string s);
    $display("test %s done", s);
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #900000;
    error_cnt++;
    test_done;
  end
  initial begin
    {rst, psel, penable, pwrite, stop_mode, timer_clear, clr} = 7'h40;
    paddr  = 8'h00;
    pwdata = 32'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(8'h28, 32'h0);
    rd(8'h2C, 32'h0);
    rd(8'h30, 32'h0);
    apb(1'b0, 8'h3C, 32'h0);
    `CHK(e, 1'b1)
    tell("reset");
    apb(1'b1, 8'h30, 32'h4);
    rd(8'h30, 32'h4);
    apb(1'b1, 8'h28, 32'h80);
    apb(1'b1, 8'h2C, 32'h40);
    meas(16384, 16500);
    `CHK(lva, 32'h2000)
    `CHK(lvb, 32'h1000)
    tell("slow select");
    apb(1'b1, 8'h30, 32'h0);
    apb(1'b1, 8'h28, 32'hFF);
    apb(1'b1, 8'h2C, 32'h0);
    meas(1024, 1100);
    `CHK(lva, 32'h3FC)
    `CHK(lvb, 32'h0)
    tell("fast");
    @(posedge clk);
    timer_clear <= 1'b1;
    @(posedge clk);
    timer_clear <= 1'b0;
    rd(8'h38, 32'h0);
    apb(1'b1, 8'h2C, 32'hFF);
    meas(900, 0);
    `CHK(lvb, 32'h0)
    `CHK(lva, 32'h384)
    tell("buffer");
    apb(1'b1, 8'h30, 32'h2);
    // One tick per 64 clocks gives ten ticks whatever the divider phase.
    @(posedge clk);
    timer_clear <= 1'b1;
    @(posedge clk);
    timer_clear <= 1'b0;
    repeat (640) @(posedge clk);
    rd(8'h38, 32'hA);
    // Wait past the next period start so channel B has loaded 0xFF.
    meas(16384, 16500);
    `CHK(lva, 32'h3FC0)
    `CHK(lvb, 32'h3FC0)
    tell("slow bus");
    @(posedge clk);
    stop_mode <= 1'b1;
    rd(8'h30, 32'h0);
    meas(200, 0);
    `CHK(lva == 32'h0 || lva == 32'hC8, 1'b1)
    apb(1'b0, 8'h34, 32'h0);
    `CHK(r[2:0], {1'b1, pin_b, pin_a})
    @(posedge clk);
    stop_mode <= 1'b0;
    meas(1024, 1100);
    `CHK(lva, 32'h3FC)
    tell("stop");
    test_done;
  end
endmodule
`default_nettype wire
